/* File: rtl/l1_cache_policy_control.sv */
// Policy and control for the level-one instruction and data caches.
// Assumes fetch/load-store pipeline requests and memory events arrive synchronous to ref_clk.
// Notes on behaviour
// - Reset: caches off, both invalidated automatically
// - Skip reset invalidate in debug recovery mode
// - Separate instruction and data cache enables
// - No line or way locking exists
// - Linefills request critical word first
// - Fetch skips icache arrays when disabled
// - Disabled icache: cacheable fetch made non-cacheable
// - Device pages fetch as non-cacheable normal
// - Fetch miss may probe dcache; allocate if enabled
// - Disabled dcache: loads/stores skip L1/L2/L3
// - Fetch allocates in L2/L3 only with dcache
// - Disabled dcache: cacheable data made non-cacheable
// - L2 enable follows data cache enable
// - Invalidate by address runs as clean-invalidate
// - Dirty data cleaned before invalidation by address
// - Set/way invalidate cleans too; override ignored
// - Allocate on read miss and write miss
// - Enter streaming: full-line stores or zero-line
// - Streaming: store misses go out, no linefill
// - Leave streaming on lost line or hits
// - Stream thresholds from extended control register
// - Line is 64 bytes fixed
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module l1_cache_policy_control
  import l1_policy_pkg::*;
#(
  parameter int unsigned HIT_WIN = 16
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          debug_recovery_mode,
  input  wire logic [l1_policy_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [31:0]                        reg_rdata,
  input  wire logic                          fetch_req,
  input  wire logic                          fetch_cacheable,
  input  wire logic                          fetch_device,
  input  wire logic                          fetch_ic_hit,
  output logic                               fetch_ic_access_ff,
  output logic                               fetch_noncache_ff,
  output logic                               fetch_dc_probe_ff,
  output logic                               fetch_dc_alloc_ff,
  output logic                               fetch_l2_alloc_ff,
  input  wire logic                          ls_req,
  input  wire logic                          ls_store,
  input  wire logic                          ls_cacheable,
  input  wire logic                          ls_hit,
  input  wire logic [l1_policy_pkg::WIDX_W-1:0] ls_word,
  output logic                               ls_array_access_ff,
  output logic                               ls_noncache_ff,
  output logic                               ls_alloc_ff,
  output logic                               ls_stream_out_ff,
  output logic [l1_policy_pkg::WIDX_W-1:0]   fill_first_word_ff,
  input  wire logic                          linefill_pending,
  input  wire logic                          store_resource_lost,
  input  wire logic [l1_policy_pkg::THR_W-1:0] stream_count,
  output logic [1:0]                         stream_dest_ff,
  input  wire logic                          mop_valid,
  input  wire l1_policy_pkg::mop_type        mop_code,
  input  wire logic                          mop_line_dirty,
  input  wire logic                          hyp_set_way_override_a32,
  input  wire logic                          hyp_set_way_override_a64,
  output logic [1:0]                         mop_action_ff,
  output logic                               mop_clean_first_ff,
  input  wire logic [1:0]                    snoop_state,
  input  wire logic                          snoop_req,
  input  wire logic                          snoop_read_shared,
  output logic [1:0]                         snoop_next_ff,
  output logic                               inval_busy_ff,
  output logic [l1_policy_pkg::SET_W-1:0]    inval_set_ff,
  output logic                               ic_en_ff,
  output logic                               dc_en_ff,
  output logic                               l2_en_ff,
  output logic                               stream_mode_ff
);
  import l1_policy_pkg::*;

  if (HIT_WIN < 2 || HIT_WIN > 255) begin : g_bad_hit_win
    $error("HIT_WIN out of range");
  end

  typedef enum logic [1:0] {
    INV_IDLE  = 2'b00,
    INV_START = 2'b01,
    INV_RUN   = 2'b10
  } inv_type;

  inv_type     inv_st_ff;
  inv_type     nxt_inv_st;
  logic [SET_W-1:0] nxt_inv_set;
  logic [31:0] xctrl_ff;
  logic        dbg_s1_ff;
  logic        dbg_s2_ff;
  logic [LINE_WORDS-1:0] store_mask_ff;
  logic [7:0]  win_cnt_ff;
  logic [7:0]  hit_cnt_ff;

  // Register decode
  wire wr_ctrl  = reg_wr && reg_addr == CTRL_OFF;
  wire wr_xctrl = reg_wr && reg_addr == XCTRL_OFF;
  wire [31:0] rd_mux = (reg_addr == CTRL_OFF)   ? {30'h0, dc_en_ff, ic_en_ff} :
                       (reg_addr == XCTRL_OFF)  ? xctrl_ff :
                       (reg_addr == STATUS_OFF) ? {28'h0, l2_en_ff, inval_busy_ff, stream_mode_ff, 1'b0} :
                                                  32'h0;

  // Streaming thresholds from extended control
  wire [THR_W-1:0] thr_l2  = xctrl_ff[XC_L2_LSB +: THR_W];
  wire [THR_W-1:0] thr_l3  = xctrl_ff[XC_L3_LSB +: THR_W];
  wire [THR_W-1:0] thr_sys = xctrl_ff[XC_SYS_LSB +: THR_W];
  wire [THR_W-1:0] thr_hit = xctrl_ff[XC_HIT_LSB +: THR_W];
  wire [1:0] nxt_dest = (stream_count >= thr_sys) ? DEST_SYS :
                        (stream_count >= thr_l3)  ? DEST_L3 : DEST_L2;

  // Fetch policy
  wire fetch_cacheable_eff = fetch_cacheable && !fetch_device;
  wire nxt_fetch_ic   = fetch_req && ic_en_ff;
  wire nxt_fetch_nc   = fetch_req && (!ic_en_ff || !fetch_cacheable_eff);
  wire fetch_miss     = fetch_req && ic_en_ff && fetch_cacheable_eff && !fetch_ic_hit;
  wire nxt_fetch_l2a  = fetch_miss && dc_en_ff;

  // Load/store policy
  // Allocation keeps no lock or pinning state
  wire ls_cache_ok    = ls_req && dc_en_ff && ls_cacheable;
  wire ls_miss        = ls_cache_ok && !ls_hit;
  wire nxt_ls_alloc   = ls_miss && !(ls_store && stream_mode_ff);
  wire nxt_ls_out     = ls_miss && ls_store && stream_mode_ff;

  // Streaming detection
  wire store_miss     = ls_miss && ls_store;
  wire [LINE_WORDS-1:0] nxt_mask = (store_mask_ff | (LINE_WORDS'(1) << ls_word));
  wire line_full      = store_miss && linefill_pending && (&nxt_mask);
  wire zero_line      = mop_valid && mop_code == MOP_ZERO_LINE;
  wire enter_stream   = line_full || zero_line;
  wire win_end        = stream_mode_ff && ls_cache_ok && ls_store && win_cnt_ff == 8'(HIT_WIN - 1);
  wire many_hits      = win_end && (hit_cnt_ff + {7'h0, ls_hit}) >= {4'h0, thr_hit};
  wire leave_stream   = store_resource_lost || many_hits;

  // Maintenance interpretation
  wire mop_addr   = mop_code == MOP_INV_ADDR || mop_code == MOP_LINV_ADDR || mop_code == MOP_CINV_ADDR;
  wire mop_sw     = mop_code == MOP_INV_SETWAY;
  // Overrides deliberately unused
  wire sw_ovr_ignored = hyp_set_way_override_a32 | hyp_set_way_override_a64;
  wire [1:0] nxt_act  = (mop_valid && (mop_addr || mop_sw)) ? (ACT_CLEAN | ACT_INVAL) : 2'b00;
  wire nxt_clean1st   = mop_valid && mop_addr && mop_line_dirty;

  // MESI next state on snoop
  function automatic logic [1:0] mesi_next(input logic [1:0] cur, input logic shared_rd);
    mesi_next = (cur == MESI_I) ? MESI_I : (shared_rd ? MESI_S : MESI_I);
  endfunction

  // Reset invalidation walk
  always_comb begin
    nxt_inv_st  = inv_st_ff;
    nxt_inv_set = inval_set_ff;
    case (inv_st_ff)
      INV_START: begin
        nxt_inv_set = '0;
        nxt_inv_st  = dbg_s2_ff ? INV_IDLE : INV_RUN;
      end
      INV_RUN: begin
        nxt_inv_set = inval_set_ff + SET_W'(1);
        if (inval_set_ff == SET_W'(INV_SETS - 1)) begin
          nxt_inv_st = INV_IDLE;
        end
      end
      INV_IDLE: begin
        nxt_inv_st = INV_IDLE;
      end
      default: begin
        nxt_inv_st = INV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    dbg_s1_ff <= debug_recovery_mode;
    dbg_s2_ff <= dbg_s1_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      inv_st_ff     <= INV_START;
      inval_set_ff  <= '0;
      inval_busy_ff <= 1'b0;
    end else begin
      inv_st_ff     <= nxt_inv_st;
      inval_set_ff  <= nxt_inv_set;
      inval_busy_ff <= (nxt_inv_st == INV_RUN);
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ic_en_ff <= 1'b0;
      dc_en_ff <= 1'b0;
      l2_en_ff <= 1'b0;
      xctrl_ff <= XCTRL_RST;
      reg_rdata <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ic_en_ff <= reg_wdata[CTRL_IC_EN];
        dc_en_ff <= reg_wdata[CTRL_DC_EN];
        l2_en_ff <= reg_wdata[CTRL_DC_EN];
      end
      if (wr_xctrl) begin
        xctrl_ff <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Policy outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetch_ic_access_ff <= 1'b0;
      fetch_noncache_ff  <= 1'b0;
      fetch_dc_probe_ff  <= 1'b0;
      fetch_dc_alloc_ff  <= 1'b0;
      fetch_l2_alloc_ff  <= 1'b0;
      ls_array_access_ff <= 1'b0;
      ls_noncache_ff     <= 1'b0;
      ls_alloc_ff        <= 1'b0;
      ls_stream_out_ff   <= 1'b0;
      fill_first_word_ff <= '0;
      mop_action_ff      <= 2'b00;
      mop_clean_first_ff <= 1'b0;
      snoop_next_ff      <= MESI_I;
      stream_dest_ff     <= DEST_L2;
    end else begin
      fetch_ic_access_ff <= nxt_fetch_ic;
      fetch_noncache_ff  <= nxt_fetch_nc;
      fetch_dc_probe_ff  <= fetch_miss;
      fetch_dc_alloc_ff  <= nxt_fetch_l2a;
      fetch_l2_alloc_ff  <= nxt_fetch_l2a;
      ls_array_access_ff <= ls_cache_ok;
      ls_noncache_ff     <= ls_req && !ls_cache_ok;
      ls_alloc_ff        <= nxt_ls_alloc;
      ls_stream_out_ff   <= nxt_ls_out;
      if (nxt_ls_alloc) begin
        fill_first_word_ff <= ls_word;
      end
      mop_action_ff      <= nxt_act;
      mop_clean_first_ff <= nxt_clean1st;
      snoop_next_ff      <= snoop_req ? mesi_next(snoop_state, snoop_read_shared) : snoop_state;
      stream_dest_ff     <= nxt_dest;
    end
  end

  // Streaming mode state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stream_mode_ff <= 1'b0;
      store_mask_ff  <= '0;
      win_cnt_ff     <= 8'h0;
      hit_cnt_ff     <= 8'h0;
    end else begin
      if (leave_stream) begin
        stream_mode_ff <= 1'b0;
      end else if (enter_stream) begin
        stream_mode_ff <= 1'b1;
      end
      if (!linefill_pending || line_full) begin
        store_mask_ff <= '0;
      end else if (store_miss) begin
        store_mask_ff <= nxt_mask;
      end
      if (!stream_mode_ff || many_hits) begin
        win_cnt_ff <= 8'h0;
        hit_cnt_ff <= 8'h0;
      end else if (ls_cache_ok && ls_store) begin
        win_cnt_ff <= (win_cnt_ff == 8'(HIT_WIN - 1)) ? 8'h0 : win_cnt_ff + 8'h1;
        hit_cnt_ff <= (win_cnt_ff == 8'(HIT_WIN - 1)) ? 8'h0 : hit_cnt_ff + {7'h0, ls_hit};
      end
    end
  end

  // Assertions
  a_reset_caches_off: assert property (@(posedge ref_clk) $fell(sys_rst) |-> !ic_en_ff && !dc_en_ff)
    else $error("caches enabled after reset");
  a_inval_walk_runs: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inv_st_ff == INV_START && !dbg_s2_ff |=> inval_busy_ff && inval_set_ff == '0)
    else $error("reset invalidate did not start");
  a_inval_skip_dbg: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inv_st_ff == INV_START && dbg_s2_ff |=> !inval_busy_ff)
    else $error("invalidate ran in debug recovery");
  a_ctrl_write_en: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_ctrl |=> ic_en_ff == $past(reg_wdata[CTRL_IC_EN]) && dc_en_ff == $past(reg_wdata[CTRL_DC_EN]))
    else $error("enable write lost");
  a_fetch_ic_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fetch_req && !ic_en_ff |=> !fetch_ic_access_ff && fetch_noncache_ff)
    else $error("fetch used disabled icache");
  a_fetch_device: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fetch_req && fetch_device |=> fetch_noncache_ff && !fetch_l2_alloc_ff)
    else $error("device fetch cached");
  a_fetch_dc_alloc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fetch_dc_alloc_ff |-> fetch_dc_probe_ff && $past(dc_en_ff))
    else $error("fetch allocated dcache line while off");
  a_fetch_alloc_dc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fetch_l2_alloc_ff |-> $past(dc_en_ff))
    else $error("fetch allocated without dcache");
  a_ls_dc_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ls_req && !dc_en_ff |=> !ls_array_access_ff && ls_noncache_ff && !ls_alloc_ff)
    else $error("data access with dcache off");
  sequence s_alloc_miss;
    ls_req && dc_en_ff && ls_cacheable && !ls_hit && !(ls_store && stream_mode_ff);
  endsequence
  a_ls_alloc_miss: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_alloc_miss |=> ls_alloc_ff && !ls_noncache_ff)
    else $error("miss did not allocate");
  a_fill_crit_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_alloc_miss |=> fill_first_word_ff == $past(ls_word))
    else $error("linefill not critical word first");
  a_l2_follow_dc: assert property (@(posedge ref_clk) disable iff (sys_rst) l2_en_ff == dc_en_ff)
    else $error("l2 enable split from dcache");
  a_inval_cleans: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mop_valid && (mop_code == MOP_INV_ADDR || mop_code == MOP_INV_SETWAY) |=> mop_action_ff == 2'b11)
    else $error("invalidate without clean");
  a_dirty_clean_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mop_valid && mop_line_dirty && (mop_code == MOP_INV_ADDR || mop_code == MOP_LINV_ADDR) |=> mop_clean_first_ff)
    else $error("dirty line invalidated without clean");
  a_snoop_shared: assert property (@(posedge ref_clk) disable iff (sys_rst)
    snoop_req && snoop_read_shared && snoop_state != MESI_I |=> snoop_next_ff == MESI_S)
    else $error("shared snoop did not share line");
  a_stream_dest_sys: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stream_count >= thr_sys |=> stream_dest_ff == DEST_SYS)
    else $error("stream destination ignores threshold");
  a_stream_reset_off: assert property (@(posedge ref_clk) sys_rst |=> !stream_mode_ff)
    else $error("streaming set after reset");
  sequence s_full_line;
    line_full && !store_resource_lost && !many_hits;
  endsequence
  a_stream_enter: assert property (@(posedge ref_clk) disable iff (sys_rst) s_full_line |=> stream_mode_ff)
    else $error("streaming not entered");
  a_zero_line_enter: assert property (@(posedge ref_clk) disable iff (sys_rst)
    zero_line && !leave_stream |=> stream_mode_ff)
    else $error("zero line did not stream");
  a_stream_store: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stream_mode_ff && ls_miss && ls_store |=> ls_stream_out_ff && !ls_alloc_ff)
    else $error("streaming store filled line");
  a_stream_leave: assert property (@(posedge ref_clk) disable iff (sys_rst) store_resource_lost |=> !stream_mode_ff)
    else $error("streaming not left");
endmodule

/* File: rtl/l1_policy_pkg.sv */
// Constants for the level-one cache policy and control block.
// Assumes a single core clock and a synchronous active-high reset.
package l1_policy_pkg;
  localparam int unsigned LINE_BYTES   = 64;
  localparam int unsigned WORD_BYTES   = 8;
  localparam int unsigned LINE_WORDS   = LINE_BYTES / WORD_BYTES;
  localparam int unsigned WIDX_W       = $clog2(LINE_WORDS);
  localparam int unsigned INV_SETS     = 16;
  localparam int unsigned SET_W        = $clog2(INV_SETS);
  // Register bus
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  CTRL_OFF     = 4'h0;
  localparam logic [3:0]  XCTRL_OFF    = 4'h4;
  localparam logic [3:0]  STATUS_OFF   = 4'h8;
  // Control register fields
  localparam int unsigned CTRL_IC_EN   = 0;
  localparam int unsigned CTRL_DC_EN   = 1;
  // Extended control: stream threshold fields
  localparam int unsigned XC_L2_LSB    = 0;
  localparam int unsigned XC_L3_LSB    = 4;
  localparam int unsigned XC_SYS_LSB   = 8;
  localparam int unsigned XC_HIT_LSB   = 12;
  localparam int unsigned THR_W        = 4;
  localparam logic [31:0] XCTRL_RST    = 32'h0000_4842;
  // Stream destinations
  typedef enum logic [1:0] {
    DEST_L2  = 2'b00,
    DEST_L3  = 2'b01,
    DEST_SYS = 2'b10
  } dest_type;
  // Maintenance operation codes
  typedef enum logic [2:0] {
    MOP_NONE        = 3'b000,
    MOP_INV_ADDR    = 3'b001,
    MOP_CINV_ADDR   = 3'b010,
    MOP_LINV_ADDR   = 3'b011,
    MOP_INV_SETWAY  = 3'b100,
    MOP_ZERO_LINE   = 3'b101
  } mop_type;
  // Maintenance action flags
  localparam logic [1:0]  ACT_CLEAN    = 2'b01;
  localparam logic [1:0]  ACT_INVAL    = 2'b10;
  // Coherence states
  typedef enum logic [1:0] {
    MESI_I = 2'b00,
    MESI_S = 2'b01,
    MESI_E = 2'b10,
    MESI_M = 2'b11
  } mesi_type;
endpackage

/* File: verif/far_mem_model.sv */
// Far-side memory model: holds a linefill outstanding after each allocate.
// Assumes the allocate pulse of the policy block and one core clock.
`timescale 1ns/1ns
module far_mem_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       fill_start,
  input  wire logic       hold_fill,
  input  wire logic [7:0] fill_lat,
  output logic            linefill_pending
);
  logic [7:0] wait_ff;
  // Fill latency, prompt or slow as the bench sets it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_ff <= 8'h00;
    end else if (fill_start) begin
      wait_ff <= fill_lat;
    end else if (wait_ff != 8'h00) begin
      wait_ff <= wait_ff - 8'h01;
    end
  end
  assign linefill_pending = hold_fill | (wait_ff != 8'h00);
endmodule

/* File: verif/l1_cache_policy_control_bench.sv */
// Self-checking bench for the cache policy block.
// Assumes the policy package and the far-side memory model.
`timescale 1ns/1ns
module l1_cache_policy_control_bench;
  import l1_policy_pkg::*;
  localparam int unsigned HW = 8;
  logic ref_clk, sys_rst, debug_recovery_mode, reg_wr, reg_rd, fetch_req, fetch_cacheable, fetch_device;
  logic fetch_ic_hit, ls_req, ls_store, ls_cacheable, ls_hit, linefill_pending, store_resource_lost;
  logic mop_valid, mop_line_dirty, hyp_set_way_override_a32, hyp_set_way_override_a64, snoop_req;
  logic snoop_read_shared, hold_fill, fetch_ic_access_ff, fetch_noncache_ff, fetch_dc_probe_ff;
  logic fetch_dc_alloc_ff, fetch_l2_alloc_ff, ls_array_access_ff, ls_noncache_ff, ls_alloc_ff;
  logic ls_stream_out_ff, mop_clean_first_ff, inval_busy_ff, ic_en_ff, dc_en_ff, l2_en_ff, stream_mode_ff;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, rd;
  logic [WIDX_W-1:0] ls_word, fill_first_word_ff, w;
  logic [THR_W-1:0]  stream_count;
  logic [1:0]        stream_dest_ff, mop_action_ff, snoop_state, snoop_next_ff;
  logic [SET_W-1:0]  inval_set_ff;
  logic [7:0]        fill_lat;
  mop_type           mop_code;
  int                error_cnt, cmp_count, k;

  l1_cache_policy_control #(.HIT_WIN(HW)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .debug_recovery_mode(debug_recovery_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_req(fetch_req), .fetch_cacheable(fetch_cacheable), .fetch_device(fetch_device),
    .fetch_ic_hit(fetch_ic_hit), .fetch_ic_access_ff(fetch_ic_access_ff), .fetch_noncache_ff(fetch_noncache_ff),
    .fetch_dc_probe_ff(fetch_dc_probe_ff), .fetch_dc_alloc_ff(fetch_dc_alloc_ff),
    .fetch_l2_alloc_ff(fetch_l2_alloc_ff), .ls_req(ls_req), .ls_store(ls_store), .ls_cacheable(ls_cacheable),
    .ls_hit(ls_hit), .ls_word(ls_word), .ls_array_access_ff(ls_array_access_ff), .ls_noncache_ff(ls_noncache_ff),
    .ls_alloc_ff(ls_alloc_ff), .ls_stream_out_ff(ls_stream_out_ff), .fill_first_word_ff(fill_first_word_ff),
    .linefill_pending(linefill_pending), .store_resource_lost(store_resource_lost),
    .stream_count(stream_count), .stream_dest_ff(stream_dest_ff), .mop_valid(mop_valid), .mop_code(mop_code),
    .mop_line_dirty(mop_line_dirty), .hyp_set_way_override_a32(hyp_set_way_override_a32),
    .hyp_set_way_override_a64(hyp_set_way_override_a64), .mop_action_ff(mop_action_ff),
    .mop_clean_first_ff(mop_clean_first_ff), .snoop_state(snoop_state), .snoop_req(snoop_req),
    .snoop_read_shared(snoop_read_shared), .snoop_next_ff(snoop_next_ff), .inval_busy_ff(inval_busy_ff),
    .inval_set_ff(inval_set_ff), .ic_en_ff(ic_en_ff), .dc_en_ff(dc_en_ff), .l2_en_ff(l2_en_ff),
    .stream_mode_ff(stream_mode_ff)
  );
  far_mem_model i_mem (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .fill_start(ls_alloc_ff), .hold_fill(hold_fill),
    .fill_lat(fill_lat), .linefill_pending(linefill_pending)
  );

  always #10 ref_clk = ~ref_clk;

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic fetch(input logic c, input logic dev);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_cacheable <= c;
    fetch_device <= dev;
    fetch_ic_hit <= 1'b0;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    #1;
  endtask
  task automatic ls(input logic st, input logic hi, input logic [WIDX_W-1:0] wd);
    @(posedge ref_clk);
    ls_req <= 1'b1;
    ls_store <= st;
    ls_cacheable <= 1'b1;
    ls_hit <= hi;
    ls_word <= wd;
    fill_lat <= 8'($urandom_range(12, 1));
    @(posedge ref_clk);
    ls_req <= 1'b0;
    #1;
  endtask
  task automatic mop(input mop_type c, input logic dirty);
    @(posedge ref_clk);
    mop_valid <= 1'b1;
    mop_code <= c;
    mop_line_dirty <= dirty;
    hyp_set_way_override_a32 <= 1'($urandom);
    hyp_set_way_override_a64 <= 1'($urandom);
    @(posedge ref_clk);
    mop_valid <= 1'b0;
    #1;
  endtask
  task automatic snoop(input logic rq, input logic [1:0] s, input logic rs);
    @(posedge ref_clk);
    snoop_req <= rq;
    snoop_state <= s;
    snoop_read_shared <= rs;
    @(posedge ref_clk);
    snoop_req <= 1'b0;
    #1;
  endtask
  task automatic wait_stream(input logic v);
    for (int n = 0; n < 6 && stream_mode_ff !== v; n++) @(posedge ref_clk) #1;
    chk_bit(stream_mode_ff, v);
    if (stream_mode_ff !== v) final_report();
  endtask
  task automatic do_reset(input logic dbg);
    int n;
    n = 0;
    debug_recovery_mode <= dbg;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (40) begin
      @(posedge ref_clk) #1;
      if (inval_busy_ff === 1'b1) begin
        chk_word(inval_set_ff, n);
        n++;
      end
    end
    chk_word(n, dbg ? 0 : 16);
    @(posedge ref_clk);
  endtask

  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {debug_recovery_mode, reg_wr, reg_rd, fetch_req, fetch_cacheable, fetch_device, fetch_ic_hit} = 7'h00;
    {ls_req, ls_store, ls_cacheable, ls_hit, store_resource_lost, mop_valid, mop_line_dirty} = 7'h00;
    {hyp_set_way_override_a32, hyp_set_way_override_a64, snoop_req, snoop_read_shared, hold_fill} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ls_word = 3'h0;
    stream_count = 4'h0;
    snoop_state = 2'h0;
    fill_lat = 8'h02;
    mop_code = MOP_NONE;
    void'($urandom(32'h3434fc0f));
    do_reset(1'b1);
    do_reset(1'b0);
    chk_bit(ic_en_ff | dc_en_ff | l2_en_ff, 1'b0);
    chk_bit(stream_mode_ff, 1'b0);
    reg_read(XCTRL_OFF);
    chk_word(rd, XCTRL_RST);
    reg_write(4'hc, 32'hffff_ffff);
    reg_read(4'hc);
    chk_word(rd, 32'h0);
    reg_read(CTRL_OFF);
    chk_word(rd, 32'h0);
    fetch(1'b1, 1'b0);
    chk_bit(fetch_ic_access_ff, 1'b0);
    chk_bit(fetch_dc_probe_ff, 1'b0);
    chk_bit(fetch_noncache_ff, 1'b1);
    chk_bit(fetch_l2_alloc_ff, 1'b0);
    ls(1'($urandom), 1'b0, 3'($urandom));
    chk_bit(ls_array_access_ff | ls_alloc_ff, 1'b0);
    chk_bit(ls_noncache_ff, 1'b1);
    mop(MOP_CINV_ADDR, 1'b1);
    chk_word(mop_action_ff, ACT_CLEAN | ACT_INVAL);
    reg_write(CTRL_OFF, 32'h1);
    chk_word({ic_en_ff, dc_en_ff, l2_en_ff}, 3'b100);
    fetch(1'b1, 1'b0);
    chk_bit(fetch_ic_access_ff, 1'b1);
    chk_bit(fetch_dc_probe_ff, 1'b1);
    chk_bit(fetch_noncache_ff, 1'b0);
    chk_bit(fetch_dc_alloc_ff | fetch_l2_alloc_ff, 1'b0);
    fetch(1'b1, 1'b1);
    chk_bit(fetch_noncache_ff, 1'b1);
    reg_write(CTRL_OFF, 32'h2);
    chk_word({ic_en_ff, dc_en_ff, l2_en_ff}, 3'b011);
    reg_write(CTRL_OFF, 32'h3);
    fetch(1'b1, 1'b0);
    chk_word({fetch_dc_alloc_ff, fetch_l2_alloc_ff}, 2'b11);
    for (int i = 0; i < 6; i++) begin
      w = 3'($urandom);
      ls(i[0], 1'b0, w);
      chk_bit(ls_alloc_ff & ls_array_access_ff & ~ls_noncache_ff, 1'b1);
      chk_word(fill_first_word_ff, w);
      repeat (14) @(posedge ref_clk);
    end
    for (int c = 1; c < 5; c++) begin
      k = $urandom_range(1, 0);
      mop(mop_type'(c), k[0]);
      chk_word(mop_action_ff, ACT_CLEAN | ACT_INVAL);
      chk_bit(mop_clean_first_ff, (c != 4) && k[0]);
    end
    for (int s = 0; s < 4; s++) begin
      snoop(1'b0, 2'(s), 1'b0);
      chk_word(snoop_next_ff, s);
      snoop(1'b1, 2'(s), 1'b0);
      chk_word(snoop_next_ff, MESI_I);
      if (s != 0) snoop(1'b1, 2'(s), 1'b1);
      if (s != 0) chk_word(snoop_next_ff, MESI_S);
    end
    for (int i = 0; i < 4; i++) begin
      if (i == 3) reg_write(XCTRL_OFF, 32'h0000_4ca2);
      @(posedge ref_clk);
      stream_count <= (i == 0) ? 4'h0 : (i == 1) ? 4'h5 : (i == 2) ? 4'hf : 4'h5;
      repeat (3) @(posedge ref_clk) #1;
      chk_word(stream_dest_ff, (i == 0 || i == 3) ? DEST_L2 : (i == 1) ? DEST_L3 : DEST_SYS);
    end
    reg_write(XCTRL_OFF, XCTRL_RST);
    @(posedge ref_clk);
    hold_fill <= 1'b1;
    k = $urandom_range(7, 0);
    for (int i = 0; i < LINE_WORDS; i++) begin
      chk_bit(stream_mode_ff, 1'b0);
      ls(1'b1, 1'b0, 3'((i * 3 + k) % 8));
    end
    wait_stream(1'b1);
    ls(1'b1, 1'b0, 3'($urandom));
    chk_word({ls_stream_out_ff, ls_alloc_ff}, 2'b10);
    ls(1'b0, 1'b0, 3'h5);
    chk_bit(ls_alloc_ff, 1'b1);
    @(posedge ref_clk);
    hold_fill <= 1'b0;
    @(posedge ref_clk);
    store_resource_lost <= 1'b1;
    @(posedge ref_clk);
    store_resource_lost <= 1'b0;
    wait_stream(1'b0);
    mop(MOP_ZERO_LINE, 1'b0);
    wait_stream(1'b1);
    reg_read(STATUS_OFF);
    chk_word(rd, 32'h0000_000a);
    repeat (HW - 1) ls(1'b1, 1'b1, 3'($urandom));
    chk_bit(stream_mode_ff, 1'b1);
    repeat (3) ls(1'b1, 1'b1, 3'($urandom));
    wait_stream(1'b0);
    final_report();
  end
endmodule
